//--- hdl/rcs_defines.svh
// Register offsets, bit positions, reset values and timing for the
// clock control/status bank. Definitions only; included by name.
`ifndef RCS_DEFINES_SVH
`define RCS_DEFINES_SVH

// Register offsets on the byte-wide bus
`define RCS_OFF_MONTH     5'h05
`define RCS_OFF_ALM_SEC   5'h08
`define RCS_OFF_ALM_MIN   5'h09
`define RCS_OFF_ALM_HOUR  5'h0A
`define RCS_OFF_ALM_DAY   5'h0B
`define RCS_OFF_DOG_FRAC  5'h0C
`define RCS_OFF_DOG_SEC   5'h0D
`define RCS_OFF_FLAGS     5'h0E
`define RCS_OFF_ENABLES   5'h0F

// Month register fields
`define RCS_B_OSC_HALT     7
`define RCS_B_CLK_OUT_OFF  6
`define RCS_B_BACKUP_CLK   5

// Alarm registers: mask in bit 7, weekday select in day reg bit 6
`define RCS_B_ALM_MASK     7
`define RCS_B_WEEKDAY_SEL  6

// Flag register fields
`define RCS_B_MAIN_LOW     7
`define RCS_B_AUX_LOW      6
`define RCS_B_HOLD_FAIL    5
`define RCS_B_PWR_RELEASE  4
`define RCS_B_ALARM_FLAG   3
`define RCS_B_KICK_FLAG    2
`define RCS_B_DOG_FLAG     1
`define RCS_B_INT_PEND     0

// Enable register fields
`define RCS_B_UPDATE_XFER  7
`define RCS_B_XTAL_SEL     6
`define RCS_B_BURST_INC    5
`define RCS_B_WAKE_EN      4
`define RCS_B_ALM_INT_EN   3
`define RCS_B_KICK_INT_EN  2
`define RCS_B_DOG_ENABLE   1
`define RCS_B_DOG_STEER    0

// Reset values
`define RCS_RST_BYTE       8'h00

// Timing (clock period and times in ns)
`define RCS_CLK_NS         10
`define RCS_DOG_STEP_NS    10_000_000
`define RCS_RST_PULSE_NS   40_000_000

`endif

//--- hdl/rcs_pkg.sv
// Types shared by the clock control/status bank and its bench.
package rcs_pkg;

  // Host bus sample, all inputs taken as synchronous
  typedef struct packed {
    logic [4:0] addr;
    logic [7:0] wdata;
    logic       chip_sel_n;
    logic       output_en_n;
    logic       write_en_n;
  } rcs_bus_t;

  // Current time from the timekeeping counters, BCD
  typedef struct packed {
    logic [6:0] seconds;
    logic [6:0] minutes;
    logic [5:0] hours;
    logic [2:0] weekday;
    logic [5:0] date;
  } rcs_time_t;

  // Open-drain pin: output value and enable
  typedef struct packed {
    logic value;
    logic enable;
  } rcs_od_t;

endpackage

//--- hdl/rcs_ctrl_regs.sv
// Control/status register bank of a battery-backed real-time clock.
// Assumes a byte-wide host bus sampled on i_clock, time counters and
// analog monitors outside, and a 32.768 kHz level on i_osc_level.
`timescale 1ns/1ps
`include "rcs_defines.svh"

module rcs_ctrl_regs #(
  parameter int unsigned P_DOG_STEP_CYC  = `RCS_DOG_STEP_NS / `RCS_CLK_NS,
  parameter int unsigned P_RST_PULSE_CYC = `RCS_RST_PULSE_NS / `RCS_CLK_NS
) (
  // Clock and reset
  input  wire logic              i_clock,
  input  wire logic              i_rst_n,
  // Host bus
  input  wire rcs_pkg::rcs_bus_t i_bus,
  output logic [7:0]             o_rdata,
  output logic                   o_rdata_oe,
  // Time and events from the counters and pins
  input  wire rcs_pkg::rcs_time_t i_time,
  input  wire logic              i_second_tick,
  input  wire logic              i_kick_in_n,
  input  wire logic              i_osc_level,
  // Supply monitors
  input  wire logic              i_main_batt_low,
  input  wire logic              i_aux_batt_low,
  input  wire logic              i_aux_batt_in,
  input  wire logic              i_on_backup,
  input  wire logic              i_power_fail,
  // Static controls to oscillator, counters and RAM path
  output logic                   o_osc_halt,
  output logic                   o_xtal_load_sel,
  output logic                   o_update_xfer_on,
  output logic                   o_ram_burst_inc,
  // Output pins
  output logic                   o_clk_out_pin,
  output rcs_pkg::rcs_od_t       o_power_on_req_n,
  output rcs_pkg::rcs_od_t       o_int_req_n,
  output rcs_pkg::rcs_od_t       o_reset_pulse_n
);
  import rcs_pkg::*;

  // Stored registers
  logic [7:0]  month;
  logic [7:0]  alm_sec;
  logic [7:0]  alm_min;
  logic [7:0]  alm_hour;
  logic [7:0]  alm_day;
  logic [7:0]  dog_frac;
  logic [7:0]  dog_sec;
  logic [7:0]  enables;
  logic        hold_on_fail;
  logic        power_release;
  logic        alarm_flag;
  logic        kick_flag;
  logic        dog_flag;
  rcs_bus_t    bus_q;
  logic        kick_q;
  logic [19:0] step_cnt;
  logic [13:0] dog_cnt;
  logic [21:0] pulse_cnt;
  logic        pulse_on;

  // Access decode: writes and reads complete when the strobe ends
  wire wr_now   = !i_bus.chip_sel_n && !i_bus.write_en_n;
  wire wr_prev  = !bus_q.chip_sel_n && !bus_q.write_en_n;
  wire wr_done  = wr_prev && !(wr_now && i_bus.addr == bus_q.addr);
  wire rd_now   = !i_bus.chip_sel_n && !i_bus.output_en_n
                  && i_bus.write_en_n;
  wire rd_flag_now  = rd_now && i_bus.addr == `RCS_OFF_FLAGS;
  wire rd_flag_prev = !bus_q.chip_sel_n && !bus_q.output_en_n
                      && bus_q.write_en_n && bus_q.addr == `RCS_OFF_FLAGS;
  wire flag_rd_clr  = rd_flag_prev && !rd_flag_now;
  wire [4:0] wa     = bus_q.addr;
  wire [7:0] wd     = bus_q.wdata;
  wire wr_flags     = wr_done && wa == `RCS_OFF_FLAGS;

  // Control fields
  wire osc_halt      = month[`RCS_B_OSC_HALT];
  wire clk_out_off   = month[`RCS_B_CLK_OUT_OFF];
  wire backup_clk_en = month[`RCS_B_BACKUP_CLK];
  wire update_xfer   = enables[`RCS_B_UPDATE_XFER];
  wire wake_en       = enables[`RCS_B_WAKE_EN];
  wire alm_int_en    = enables[`RCS_B_ALM_INT_EN];
  wire kick_int_en   = enables[`RCS_B_KICK_INT_EN];
  wire dog_enable    = enables[`RCS_B_DOG_ENABLE];
  wire dog_steer     = enables[`RCS_B_DOG_STEER];

  // Alarm compare; masks ordered {day.. seconds} highest first
  wire [3:0] mask = {alm_day[`RCS_B_ALM_MASK], alm_hour[`RCS_B_ALM_MASK],
                     alm_min[`RCS_B_ALM_MASK], alm_sec[`RCS_B_ALM_MASK]};
  wire sec_eq  = alm_sec[6:0] == i_time.seconds;
  wire min_eq  = alm_min[6:0] == i_time.minutes;
  wire hour_eq = alm_hour[5:0] == i_time.hours;
  wire day_eq  = alm_day[`RCS_B_WEEKDAY_SEL]
                 ? alm_day[5:0] == {3'h0, i_time.weekday}
                 : alm_day[5:0] == i_time.date;
  logic alm_match;
  // Table of legal mask patterns; anything else repeats every second
  always_comb
  begin
    case (mask)
      4'hF:    alm_match = 1'b1;
      4'hE:    alm_match = sec_eq;
      4'hC:    alm_match = sec_eq && min_eq;
      4'h8:    alm_match = sec_eq && min_eq && hour_eq;
      4'h0:    alm_match = sec_eq && min_eq && hour_eq && day_eq;
      default: alm_match = 1'b1;
    endcase
  end
  // Alarms only land while transfers run and the oscillator ticks
  wire alarm_evt = i_second_tick && update_xfer && !osc_halt
                   && alm_match;
  wire kick_evt  = kick_q && !i_kick_in_n;

  // Watchdog: BCD registers to a count of 10 ms steps
  // Widen before multiplying so 9000 and 900 do not wrap
  wire [13:0] dog_load = 14'(dog_sec[7:4]) * 14'h03E8
                       + 14'(dog_sec[3:0]) * 14'h0064
                       + 14'(dog_frac[7:4]) * 14'h000A
                       + 14'(dog_frac[3:0]);
  wire dog_armed = dog_load != 14'h0000;
  wire step_end  = step_cnt == 20'(P_DOG_STEP_CYC - 1);
  wire dog_evt   = dog_armed && step_end && dog_cnt == 14'h0001;
  wire pulse_start = dog_evt && dog_enable && dog_steer;

  // Set wins over any clear in the same cycle
  wire next_alarm = alarm_evt
                 || (alarm_flag && !flag_rd_clr
                     && !(wr_flags && !wd[`RCS_B_ALARM_FLAG]));
  wire next_kick  = kick_evt || (wr_flags && wd[`RCS_B_KICK_FLAG])
                 || (kick_flag && !flag_rd_clr && !wr_flags);
  wire next_dog   = dog_evt
                 || (dog_flag && !flag_rd_clr
                     && !(wr_flags && !wd[`RCS_B_DOG_FLAG]));
  wire int_pending = (alarm_flag && alm_int_en)
                  || (kick_flag && kick_int_en)
                  || (dog_flag && dog_enable);

  // Release bit: host writes it, wake or kick events force it to 0
  wire rel_clear = (alarm_flag && wake_en) || kick_flag;
  wire next_release = rel_clear ? 1'b0
                    : (wr_flags ? wd[`RCS_B_PWR_RELEASE]
                                : power_release);

  // Bus sample, edge history and flags
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      bus_q         <= '{addr: 5'h00, wdata: 8'h00, chip_sel_n: 1'b1,
                         output_en_n: 1'b1, write_en_n: 1'b1};
      kick_q        <= 1'b1;
      alarm_flag    <= 1'b0;
      kick_flag     <= 1'b0;
      dog_flag      <= 1'b0;
      power_release <= 1'b0;
      hold_on_fail  <= 1'b0;
    end
    else
    begin
      bus_q         <= i_bus;
      kick_q        <= i_kick_in_n;
      alarm_flag    <= next_alarm;
      kick_flag     <= next_kick;
      dog_flag      <= next_dog;
      power_release <= next_release;
      if (wr_flags)
        hold_on_fail <= wd[`RCS_B_HOLD_FAIL];
    end
  end

  // Host-writable registers; reset also covers bits left undefined
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      month    <= `RCS_RST_BYTE;
      enables  <= `RCS_RST_BYTE;
      alm_sec  <= `RCS_RST_BYTE;
      alm_min  <= `RCS_RST_BYTE;
      alm_hour <= `RCS_RST_BYTE;
      alm_day  <= `RCS_RST_BYTE;
      dog_frac <= `RCS_RST_BYTE;
      dog_sec  <= `RCS_RST_BYTE;
    end
    else
    begin
      if (wr_done && wa == `RCS_OFF_MONTH)    month    <= wd;
      if (wr_done && wa == `RCS_OFF_ALM_SEC)  alm_sec  <= wd;
      if (wr_done && wa == `RCS_OFF_ALM_MIN)  alm_min  <= wd;
      if (wr_done && wa == `RCS_OFF_ALM_HOUR) alm_hour <= wd;
      if (wr_done && wa == `RCS_OFF_ALM_DAY)  alm_day  <= wd;
      if (wr_done && wa == `RCS_OFF_DOG_FRAC) dog_frac <= wd;
      if (wr_done && wa == `RCS_OFF_DOG_SEC)  dog_sec  <= wd;
      if (wr_done && wa == `RCS_OFF_ENABLES)  enables  <= wd;
      else if (pulse_start)
        enables[`RCS_B_DOG_ENABLE] <= 1'b0;
    end
  end

  // Watchdog countdown; any host write restarts the period
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      step_cnt <= 20'h0_0000;
      dog_cnt  <= 14'h0000;
    end
    // An empty count picks up a load written in the cycle before
    else if (wr_done || !dog_armed || dog_cnt == 14'h0000)
    begin
      step_cnt <= 20'h0_0000;
      dog_cnt  <= dog_load;
    end
    else if (step_end)
    begin
      step_cnt <= 20'h0_0000;
      dog_cnt  <= (dog_cnt == 14'h0001) ? dog_load : dog_cnt - 14'h0001;
    end
    else
      step_cnt <= step_cnt + 20'h0_0001;
  end

  // Reset pulse timer, held to the shortest legal width
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      pulse_on  <= 1'b0;
      pulse_cnt <= 22'h00_0000;
    end
    else if (pulse_start && !pulse_on)
    begin
      pulse_on  <= 1'b1;
      pulse_cnt <= 22'(P_RST_PULSE_CYC - 1);
    end
    else if (pulse_on)
    begin
      pulse_on  <= pulse_cnt != 22'h00_0000;
      pulse_cnt <= pulse_cnt - 22'h00_0001;
    end
  end

  // Read data mux; time registers belong to the counter block
  wire [7:0] flags_rd = {i_main_batt_low, i_aux_batt_low, hold_on_fail,
                         power_release, alarm_flag, kick_flag, dog_flag,
                         int_pending};
  logic [7:0] next_rdata;
  always_comb
  begin
    case (i_bus.addr)
      `RCS_OFF_MONTH:    next_rdata = month;
      `RCS_OFF_ALM_SEC:  next_rdata = alm_sec;
      `RCS_OFF_ALM_MIN:  next_rdata = alm_min;
      `RCS_OFF_ALM_HOUR: next_rdata = alm_hour;
      `RCS_OFF_ALM_DAY:  next_rdata = alm_day;
      `RCS_OFF_DOG_FRAC: next_rdata = dog_frac;
      `RCS_OFF_DOG_SEC:  next_rdata = dog_sec;
      `RCS_OFF_FLAGS:    next_rdata = flags_rd;
      `RCS_OFF_ENABLES:  next_rdata = enables;
      default:           next_rdata = 8'h00;
    endcase
  end

  // Clock output: normal supply, or backup with aux battery present
  wire clk_gate = !osc_halt && (i_on_backup
                  ? (backup_clk_en && i_aux_batt_in)
                  : !clk_out_off);
  // Power request drops on power-fail unless told to hold
  wire pwr_drive = !power_release
                   && !(i_power_fail && !hold_on_fail);

  // Registered data outputs
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_rdata       <= 8'h00;
      o_clk_out_pin <= 1'b0;
    end
    else
    begin
      o_rdata       <= next_rdata;
      o_clk_out_pin <= clk_gate && i_osc_level;
    end
  end

  // Handshake and static outputs
  assign o_rdata_oe       = rd_now;
  assign o_osc_halt       = osc_halt;
  assign o_xtal_load_sel  = enables[`RCS_B_XTAL_SEL];
  assign o_update_xfer_on = update_xfer;
  assign o_ram_burst_inc  = enables[`RCS_B_BURST_INC];
  assign o_power_on_req_n = '{value: 1'b0, enable: pwr_drive};
  assign o_int_req_n      = '{value: 1'b0, enable: int_pending};
  assign o_reset_pulse_n  = '{value: 1'b0, enable: pulse_on};

endmodule

//--- tb/rcs_ctrl_regs_props.sv
// Port checker for the clock control/status bank.
// Assumes one clock domain and a read path registered one cycle.
`timescale 1ns/1ps
module rcs_ctrl_regs_props #(
  parameter int unsigned P_RST_PULSE_CYC = 8
) (
  // Clock and reset
  input wire logic              i_clock,
  input wire logic              i_rst_n,
  // Bus, events and monitors
  input wire rcs_pkg::rcs_bus_t i_bus,
  input wire logic [7:0]        o_rdata,
  input wire logic              o_rdata_oe,
  input wire logic              i_kick_in_n,
  input wire logic              i_main_batt_low,
  input wire logic              i_aux_batt_low,
  input wire logic              i_power_fail,
  // Controls and pins
  input wire logic              o_osc_halt,
  input wire logic              o_xtal_load_sel,
  input wire logic              o_update_xfer_on,
  input wire logic              o_ram_burst_inc,
  input wire logic              o_clk_out_pin,
  input wire rcs_pkg::rcs_od_t  o_power_on_req_n,
  input wire rcs_pkg::rcs_od_t  o_int_req_n,
  input wire rcs_pkg::rcs_od_t  o_reset_pulse_n
);
  import rcs_pkg::*;
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  logic [31:0] pulse_cnt;
  // Length of the reset pulse; too long to unroll as a repetition
  always_ff @(posedge i_clock or negedge i_rst_n)
    if (!i_rst_n)
      pulse_cnt <= '0;
    else
      pulse_cnt <= o_reset_pulse_n.enable ? pulse_cnt + 1 : '0;
  batt_mirror_a: assert property ($past(i_bus.addr) == 5'h0e |->
    o_rdata[7:6] == {$past(i_main_batt_low), $past(i_aux_batt_low)})
    else $error("battery bits differ from monitors");
  power_drive_a: assert property ($past(i_bus.addr) == 5'h0e |->
    $past(o_power_on_req_n.enable) ==
    (!o_rdata[4] && !($past(i_power_fail) && !o_rdata[5])))
    else $error("power request pin disagrees with its bits");
  int_pend_a: assert property ($past(i_bus.addr) == 5'h0e |->
    o_rdata[0] == $past(o_int_req_n.enable))
    else $error("pending bit disagrees with interrupt pin");
  ctrl_bits_a: assert property ($past(i_bus.addr) == 5'h0f |->
    o_rdata[7:5] == {$past(o_update_xfer_on), $past(o_xtal_load_sel),
    $past(o_ram_burst_inc)})
    else $error("static controls differ from enable register");
  osc_bit_a: assert property ($past(i_bus.addr) == 5'h05 |->
    o_rdata[7] == $past(o_osc_halt))
    else $error("oscillator control differs from month register");
  unmapped_zero_a: assert property ($past(i_bus.addr) inside
    {[5'h00:5'h04], 5'h06, 5'h07, [5'h10:5'h1f]} |-> o_rdata == 8'h00)
    else $error("unmapped address read not zero");
  clk_gate_a: assert property (o_osc_halt && $past(o_osc_halt) |->
    !o_clk_out_pin)
    else $error("clock output runs with oscillator halted");
  pulse_len_a: assert property ($fell(o_reset_pulse_n.enable) |->
    pulse_cnt == P_RST_PULSE_CYC)
    else $error("reset pulse length wrong");
  kick_wake_a: assert property ($fell(i_kick_in_n) && !i_power_fail
    |-> ##[1:6] o_power_on_req_n.enable)
    else $error("kickstart did not drive power request");
  read_oe_a: assert property (o_rdata_oe == (!i_bus.chip_sel_n &&
    !i_bus.output_en_n && i_bus.write_en_n))
    else $error("read enable does not follow strobes");
  cover property ($fell(o_reset_pulse_n.enable));
  cover property ($rose(o_int_req_n.enable));
  cover property ($past(i_bus.addr) == 5'h0e && o_rdata[3]);
endmodule

bind rcs_ctrl_regs rcs_ctrl_regs_props #(.P_RST_PULSE_CYC(P_RST_PULSE_CYC))
  u_props (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_bus(i_bus),
  .o_rdata(o_rdata), .o_rdata_oe(o_rdata_oe), .i_kick_in_n(i_kick_in_n),
  .i_main_batt_low(i_main_batt_low), .i_aux_batt_low(i_aux_batt_low),
  .i_power_fail(i_power_fail), .o_osc_halt(o_osc_halt),
  .o_xtal_load_sel(o_xtal_load_sel), .o_update_xfer_on(o_update_xfer_on),
  .o_ram_burst_inc(o_ram_burst_inc), .o_clk_out_pin(o_clk_out_pin),
  .o_power_on_req_n(o_power_on_req_n), .o_int_req_n(o_int_req_n),
  .o_reset_pulse_n(o_reset_pulse_n));

//--- tb/rcs_host_model.sv
// Host processor model driving the byte-wide register bus.
// Assumes the bank samples the bus on the rising edge of i_clock.
`timescale 1ns/1ps
module rcs_host_model (
  // Clock and read data
  input  wire logic        i_clock,
  input  wire logic [7:0]  i_rdata,
  // Bus to the bank
  output rcs_pkg::rcs_bus_t o_bus
);
  import rcs_pkg::*;
  initial o_bus = '{5'h00, 8'h00, 1'b1, 1'b1, 1'b1};
  // Write: strobes two cycles, stale data inverted once released
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge i_clock);
    o_bus <= '{a, d, 1'b0, 1'b1, 1'b0};
    repeat (2) @(posedge i_clock);
    o_bus <= '{a, ~d, 1'b1, 1'b1, 1'b1};
    repeat (2) @(posedge i_clock);
  endtask
  // Read: data taken at the last edge before strobes rise
  task automatic rd(input logic [4:0] a, output logic [7:0] d);
    @(posedge i_clock);
    o_bus <= '{a, 8'h5a, 1'b0, 1'b0, 1'b1};
    repeat (2) @(posedge i_clock);
    d = i_rdata;
    o_bus <= '{a, 8'ha5, 1'b1, 1'b1, 1'b1};
    repeat (2) @(posedge i_clock);
  endtask
endmodule

//--- tb/testbench.sv
// Self-checking bench for the clock control/status bank.
// Assumes the host model drives the bus; short watchdog counts.
`timescale 1ns/1ps
module testbench;
  import rcs_pkg::*;
  localparam int unsigned DOG_STEP  = 4;
  localparam int unsigned RST_PULSE = 8;
  logic i_clock = 1'b0;
  logic i_rst_n = 1'b0;
  logic tick = 1'b0, kick_n = 1'b1, osc = 1'b0, pfail = 1'b0;
  logic main_low = 1'b0, aux_low = 1'b0;
  logic on_bk = 1'b0, aux_in = 1'b1;
  logic oe, osc_halt, xtal, xfer, burst, clk_pin;
  logic [7:0] rdata, got, d;
  rcs_bus_t  bus;
  rcs_time_t tim = '{7'h30, 7'h45, 6'h12, 3'h3, 6'h15};
  rcs_od_t   power_on_req_n, irq, rst;
  int n_errors = 0;
  int n_compared = 0;
  int c;
  int model [int];
  // Alarm cases: sec, min, hour, day, enables, fire
  logic [47:0] alm [6] = '{48'h8080_8080_8801, 48'h8080_0080_8801,
    48'h3045_1215_8801, 48'h3045_1216_8800, 48'h3045_1243_8801,
    48'h8080_8080_0800};
  always #5 i_clock = ~i_clock;
  // Fast stand-in for the oscillator level
  always @(posedge i_clock) osc <= ~osc;
  rcs_ctrl_regs #(.P_DOG_STEP_CYC(DOG_STEP), .P_RST_PULSE_CYC(RST_PULSE))
    uut (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_bus(bus),
    .o_rdata(rdata), .o_rdata_oe(oe), .i_time(tim), .i_second_tick(tick),
    .i_kick_in_n(kick_n), .i_osc_level(osc), .i_main_batt_low(main_low),
    .i_aux_batt_low(aux_low), .i_aux_batt_in(aux_in), .i_on_backup(on_bk),
    .i_power_fail(pfail), .o_osc_halt(osc_halt), .o_xtal_load_sel(xtal),
    .o_update_xfer_on(xfer), .o_ram_burst_inc(burst),
    .o_clk_out_pin(clk_pin), .o_power_on_req_n(power_on_req_n), .o_int_req_n(irq),
    .o_reset_pulse_n(rst));
  rcs_host_model host (.i_clock(i_clock), .i_rdata(rdata), .o_bus(bus));
  task automatic end_of_test;
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, logic [7:0] g);
    n_compared++;
    if (g !== e)
    begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_pin(input string nm, input logic e, input logic g);
    chk(nm, {7'h00, e}, {7'h00, g});
  endtask
  task automatic wreg(input logic [4:0] a, input logic [7:0] v);
    host.wr(a, v);
    model[a] = v;
  endtask
  task automatic rchk(input logic [4:0] a, input logic [7:0] e);
    host.rd(a, got);
    chk($sformatf("reg %h", a), e, got);
  endtask
  // One-cycle second tick, then time for the flag to land
  task automatic tick1;
    @(posedge i_clock) tick <= 1'b1;
    @(posedge i_clock) tick <= 1'b0;
    repeat (2) @(posedge i_clock);
  endtask
  // Bounded wait for the reset or interrupt pin to be driven
  task automatic wait_en(input bit use_rst);
    c = 0;
    while ((use_rst ? rst.enable : irq.enable) !== 1'b1 && c < 200)
    begin
      @(posedge i_clock);
      #1 c++;
    end
    if (c >= 200)
    begin
      chk("wait", 8'h01, 8'h00);
      end_of_test();
    end
  endtask
  initial
  begin
    void'($urandom(32'hc0273d58));
    repeat (10) @(posedge i_clock);
    i_rst_n <= 1'b1;
    rchk(5'h05, 8'h00);
    rchk(5'h0f, 8'h00);
    rchk(5'h0e, 8'h00);
    chk_pin("power", 1'b1, power_on_req_n.enable);
    for (int i = 0; i < 4; i++)
    begin
      d = $urandom;
      wreg(5'h05, d);
      rchk(5'h05, 8'(model[5]));
      chk_pin("osc_halt", d[7], osc_halt);
      if (d[7] | d[6]) chk_pin("clk_out", 1'b0, clk_pin);
      else chk_pin("clk_out", ~osc, clk_pin);
      wreg(5'h0f, d & 8'he0);
      chk("ctl", {5'h00, d[7:5]}, {5'h00, xfer, xtal, burst});
      rchk(5'h0f, 8'(model[15]));
    end
    wreg(5'h05, 8'h00);
    // Backup supply: output only with its enable and aux battery
    @(posedge i_clock) on_bk <= 1'b1;
    wreg(5'h05, 8'h20);
    chk_pin("backup_clk", ~osc, clk_pin);
    @(posedge i_clock) aux_in <= 1'b0;
    repeat (2) @(posedge i_clock);
    chk_pin("backup_clk", 1'b0, clk_pin);
    @(posedge i_clock) {on_bk, aux_in} <= 2'b01;
    wreg(5'h05, 8'h00);
    wreg(5'h03, 8'hff);
    rchk(5'h03, 8'h00);
    rchk(5'h10, 8'h00);
    @(posedge i_clock) main_low <= 1'b1;
    wreg(5'h0e, 8'hc0);
    rchk(5'h0e, 8'h80);
    @(posedge i_clock) {main_low, aux_low} <= 2'b01;
    rchk(5'h0e, 8'h40);
    @(posedge i_clock) aux_low <= 1'b0;
    wreg(5'h0e, 8'h10);
    chk_pin("power", 1'b0, power_on_req_n.enable);
    wreg(5'h0e, 8'h00);
    @(posedge i_clock) pfail <= 1'b1;
    @(posedge i_clock);
    chk_pin("power", 1'b0, power_on_req_n.enable);
    wreg(5'h0e, 8'h20);
    chk_pin("power", 1'b1, power_on_req_n.enable);
    @(posedge i_clock) pfail <= 1'b0;
    for (int i = 0; i < 6; i++)
    begin
      for (int r = 8; r < 12; r++) wreg(r[4:0], alm[i][47-8*(r-8) -: 8]);
      wreg(5'h0f, alm[i][15:8]);
      wreg(5'h0e, 8'h00);
      tick1();
      chk_pin("irq", alm[i][0], irq.enable);
      rchk(5'h0e, alm[i][0] ? 8'h09 : 8'h00);
    end
    wreg(5'h0e, 8'h10);
    wreg(5'h0f, 8'h98);
    tick1();
    chk_pin("power", 1'b1, power_on_req_n.enable);
    rchk(5'h0e, 8'h09);
    wreg(5'h0f, 8'h04);
    wreg(5'h0e, 8'h10);
    @(posedge i_clock) kick_n <= 1'b0;
    repeat (6) @(posedge i_clock);
    kick_n <= 1'b1;
    chk_pin("irq", 1'b1, irq.enable);
    rchk(5'h0e, 8'h05);
    rchk(5'h0e, 8'h00);
    chk_pin("irq", 1'b0, irq.enable);
    wreg(5'h0e, 8'h04);
    rchk(5'h0e, 8'h05);
    wreg(5'h0d, 8'h00);
    wreg(5'h0f, 8'h03);
    wreg(5'h0c, 8'h02);
    wait_en(1'b1);
    c = 0;
    while (rst.enable === 1'b1 && c < 50)
    begin
      @(posedge i_clock);
      #1 c++;
    end
    chk("pulse", 8'(RST_PULSE), 8'(c));
    chk_pin("irq", 1'b0, irq.enable);
    wreg(5'h0c, 8'h00);
    rchk(5'h0f, 8'h01);
    rchk(5'h0e, 8'h02);
    wreg(5'h0f, 8'h02);
    wreg(5'h0c, 8'h10);
    wait_en(1'b0);
    chk("bcd", 8'(10 * DOG_STEP), 8'(c));
    chk_pin("reset", 1'b0, rst.enable);
    wreg(5'h0c, 8'h00);
    rchk(5'h0e, 8'h03);
    wreg(5'h0e, 8'h00);
    rchk(5'h0e, 8'h00);
    // Mid-run reset must clear bits the host has just set
    wreg(5'h05, 8'hc0);
    wreg(5'h0f, 8'h0f);
    @(posedge i_clock) i_rst_n <= 1'b0;
    repeat (2) @(posedge i_clock);
    i_rst_n <= 1'b1;
    rchk(5'h05, 8'h00);
    rchk(5'h0f, 8'h00);
    end_of_test();
  end
endmodule
